// ==== uix_regs.vh ====
// Constants for the unit I/O executor; bit 0 is the word's most significant bit,
// held here as index 15 of a [15:0] vector.
`ifndef UIX_REGS_VH
`define UIX_REGS_VH
`define UIX_OP_CMD_TEST 4'hB
`define UIX_OP_MEM_ACC 4'hF
`define UIX_AUG_CEU_SKIP 3'h0
`define UIX_AUG_CEU_WAIT 3'h1
`define UIX_AUG_TEU 3'h2
`define UIX_AUG_MOP_SKIP 3'h4
`define UIX_AUG_MOP_WAIT 3'h5
`define UIX_AUG_MIP_SKIP 3'h6
`define UIX_AUG_MIP_WAIT 3'h7
`define UIX_AOP_SKIP 10'h3C0
`define UIX_AOP_WAIT 10'h3C1
`define UIX_AIP_SKIP 10'h3C2
`define UIX_AIP_WAIT 10'h3C3
`define UIX_AIP_MSKIP 10'h3E2
`define UIX_AIP_MWAIT 10'h3E3
`define UIX_UNIT_NONE 6'h00
`define UIX_MCYC_NS 1750
`define UIX_CLK_NS 5
`define UIX_MCYC_CLKS (`UIX_MCYC_NS / `UIX_CLK_NS)
`define UIX_INTR_BASE 15'h0001
`define UIX_SPB_IND 16'h9000
`define UIX_AXI_CTRL 4'h0
`define UIX_AXI_INSTR 4'h4
`define UIX_AXI_OPER 4'h8
`define UIX_AXI_ACCUM 4'hC
`endif

// ==== uix_top.v ====
// Unit I/O instruction executor with AXI4-Lite register access.
// Assumes one 200 MHz clock; bus pins from units arrive asynchronously.
`include "uix_regs.vh"
module uix_top #(
  parameter MCYC_CLKS = `UIX_MCYC_CLKS
) (
  input wire I_CLOCK, // 200 MHz
  input wire I_ARST_N, // Async reset, low
  input wire [3:0] I_AWADDR, // Write address
  input wire I_AWVALID, // Write address valid
  output wire O_AWREADY, // Write address ready
  input wire [31:0] I_WDATA, // Write data
  input wire [3:0] I_WSTRB, // Write strobes
  input wire I_WVALID, // Write data valid
  output wire O_WREADY, // Write data ready
  output reg [1:0] O_BRESP, // Write response
  output reg O_BVALID, // Write response valid
  input wire I_BREADY, // Write response ready
  input wire [3:0] I_ARADDR, // Read address
  input wire I_ARVALID, // Read address valid
  output wire O_ARREADY, // Read address ready
  output reg [31:0] O_RDATA, // Read data
  output reg [1:0] O_RRESP, // Read response
  output reg O_RVALID, // Read data valid
  input wire I_RREADY, // Read data ready
  output reg [5:0] O_UNIT, // Unit number on bus
  output reg [15:0] O_BUS_OUT, // Word to unit
  output reg O_BUS_OE, // Word drivers on
  output reg O_CMD_STB, // Command strobe
  output reg O_TEST_STB, // Test strobe
  output reg O_DOUT_STB, // Data out strobe
  output reg O_DIN_STB, // Data in strobe
  output reg O_CHAR_MODE, // Character unit flag
  input wire [15:0] I_BUS_IN, // Word from unit
  input wire I_RET_SYNC, // Return sync pulse
  input wire I_RET_TEST, // Return test level
  output reg [14:0] O_MEM_ADDR, // Memory word address
  output reg [15:0] O_MEM_WDATA, // Memory write data
  output reg O_MEM_WE, // Memory write
  input wire I_IRQ, // Priority interrupt
  input wire I_IRQ_LVL, // Interrupt level
  output reg [14:0] O_FORCE_ADDR, // Forced vector address
  output reg [15:0] O_FORCE_INSTR, // Forced branch code
  output reg O_FORCE_VALID // Forced fetch valid
);
  localparam ST_IDLE = 2'h0;
  localparam ST_TEST = 2'h1;
  localparam ST_XFER = 2'h2;
  localparam ST_DONE = 2'h3;
  reg rst_a_r, rst_r;
  wire rst_n = rst_r;
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_a_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_r <= rst_a_r;
    end
  end
  // Unit return pins cross in through two stages
  reg [15:0] din_a_r, din_r;
  reg sync_a_r, sync_r, test_a_r, test_r, irq_a_r, irq_r, lvl_a_r, lvl_r;
  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      din_a_r <= 16'h0000;
      din_r <= 16'h0000;
      sync_a_r <= 1'b0;
      sync_r <= 1'b0;
      test_a_r <= 1'b0;
      test_r <= 1'b0;
      irq_a_r <= 1'b0;
      irq_r <= 1'b0;
      lvl_a_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      din_a_r <= I_BUS_IN;
      din_r <= din_a_r;
      sync_a_r <= I_RET_SYNC;
      sync_r <= sync_a_r;
      test_a_r <= I_RET_TEST;
      test_r <= test_a_r;
      irq_a_r <= I_IRQ;
      irq_r <= irq_a_r;
      lvl_a_r <= I_IRQ_LVL;
      lvl_r <= lvl_a_r;
    end
  end
  // Machine cycle enable from divider
  reg [10:0] div_r;
  wire mcyc = (div_r == MCYC_CLKS - 1);
  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n)
      div_r <= 11'h000;
    else if (mcyc)
      div_r <= 11'h000;
    else
      div_r <= div_r + 11'h001;
  end
  // Software registers
  reg [15:0] instr_r, oper_r, accum_r, pc_r;
  reg go_r, busy_r, skipped_r, char_r;
  wire wr_take = I_AWVALID && I_WVALID && !O_BVALID;
  // A go written on a start tick must survive the tick's clear
  wire go_set = wr_take && I_AWADDR == `UIX_AXI_CTRL && I_WSTRB[0] && I_WDATA[0] && !busy_r;
  assign O_AWREADY = wr_take;
  assign O_WREADY = wr_take;
  assign O_ARREADY = !O_RVALID;
  wire [15:0] wlo = {I_WSTRB[1] ? I_WDATA[15:8] : 8'h00, I_WSTRB[0] ? I_WDATA[7:0] : 8'h00};
  function decode_ok;
    input [3:0] a;
    begin
      decode_ok = (a == `UIX_AXI_CTRL) || (a == `UIX_AXI_INSTR) || (a == `UIX_AXI_OPER) || (a == `UIX_AXI_ACCUM);
    end
  endfunction
  // Decode
  wire [3:0] op = instr_r[15:12];
  // Augment sits above the unit field so every unit number stays usable
  wire [2:0] aug = instr_r[8:6];
  wire is_aop = instr_r[15:6] == `UIX_AOP_SKIP || instr_r[15:6] == `UIX_AOP_WAIT;
  wire is_aip = instr_r[15:6] == `UIX_AIP_SKIP || instr_r[15:6] == `UIX_AIP_WAIT ||
                instr_r[15:6] == `UIX_AIP_MSKIP || instr_r[15:6] == `UIX_AIP_MWAIT;
  wire is_ceu = op == `UIX_OP_CMD_TEST && (aug == `UIX_AUG_CEU_SKIP || aug == `UIX_AUG_CEU_WAIT);
  wire is_teu = op == `UIX_OP_CMD_TEST && aug == `UIX_AUG_TEU;
  wire is_mop = op == `UIX_OP_MEM_ACC && (aug == `UIX_AUG_MOP_SKIP || aug == `UIX_AUG_MOP_WAIT);
  wire is_mip = op == `UIX_OP_MEM_ACC && (aug == `UIX_AUG_MIP_SKIP || aug == `UIX_AUG_MIP_WAIT);
  wire wait_md = aug[0];
  wire merge = instr_r[11];
  wire ind = instr_r[10];
  wire map = instr_r[11];
  wire out_dir = is_ceu || is_teu || is_mop || is_aop;
  wire [14:0] eff_addr = {map ? pc_r[14] : 1'b0, oper_r[13:0]};
  reg [1:0] st_r;
  always @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      O_UNIT <= `UIX_UNIT_NONE;
      O_BUS_OUT <= 16'h0000;
      O_BUS_OE <= 1'b0;
      O_CMD_STB <= 1'b0;
      O_TEST_STB <= 1'b0;
      O_DOUT_STB <= 1'b0;
      O_DIN_STB <= 1'b0;
      O_CHAR_MODE <= 1'b0;
      O_MEM_ADDR <= 15'h0000;
      O_MEM_WDATA <= 16'h0000;
      O_MEM_WE <= 1'b0;
      O_FORCE_ADDR <= 15'h0000;
      O_FORCE_INSTR <= 16'h0000;
      O_FORCE_VALID <= 1'b0;
      instr_r <= 16'h0000;
      oper_r <= 16'h0000;
      accum_r <= 16'h0000;
      pc_r <= 16'h0000;
      go_r <= 1'b0;
      busy_r <= 1'b0;
      skipped_r <= 1'b0;
      char_r <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= 2'h0;
      O_RVALID <= 1'b0;
      O_RRESP <= 2'h0;
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_MEM_WE <= 1'b0;
      O_CMD_STB <= 1'b0;
      O_TEST_STB <= 1'b0;
      O_DOUT_STB <= 1'b0;
      O_DIN_STB <= 1'b0;
      O_FORCE_VALID <= 1'b0;
      if (irq_r && st_r == ST_IDLE && !go_r) begin
        O_FORCE_ADDR <= `UIX_INTR_BASE + {14'h0000, lvl_r};
        O_FORCE_INSTR <= `UIX_SPB_IND;
        O_FORCE_VALID <= 1'b1;
      end
      if (wr_take) begin
        O_BVALID <= 1'b1;
        O_BRESP <= decode_ok(I_AWADDR) ? 2'h0 : 2'h2;
        if (I_AWADDR == `UIX_AXI_CTRL) begin
          if (I_WSTRB[0] && I_WDATA[0] && !busy_r)
            go_r <= 1'b1;
          if (I_WSTRB[0])
            char_r <= I_WDATA[1];
          if (I_WSTRB[2] || I_WSTRB[3])
            pc_r <= {I_WSTRB[3] ? I_WDATA[31:24] : pc_r[15:8], I_WSTRB[2] ? I_WDATA[23:16] : pc_r[7:0]};
        end else if (I_AWADDR == `UIX_AXI_INSTR && !busy_r)
          instr_r <= wlo;
        else if (I_AWADDR == `UIX_AXI_OPER && !busy_r)
          oper_r <= wlo;
        else if (I_AWADDR == `UIX_AXI_ACCUM && !busy_r)
          accum_r <= wlo;
      end else if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
      if (I_ARVALID && !O_RVALID) begin
        O_RVALID <= 1'b1;
        O_RRESP <= decode_ok(I_ARADDR) ? 2'h0 : 2'h2;
        if (I_ARADDR == `UIX_AXI_CTRL)
          O_RDATA <= {pc_r, 12'h000, skipped_r, busy_r, char_r, go_r};
        else if (I_ARADDR == `UIX_AXI_INSTR)
          O_RDATA <= {16'h0000, instr_r};
        else if (I_ARADDR == `UIX_AXI_OPER)
          O_RDATA <= {16'h0000, oper_r};
        else if (I_ARADDR == `UIX_AXI_ACCUM)
          O_RDATA <= {16'h0000, accum_r};
        else
          O_RDATA <= 32'h0000_0000;
      end else if (O_RVALID && I_RREADY)
        O_RVALID <= 1'b0;
      if (mcyc) begin
        case (st_r)
          ST_IDLE: begin
            if (go_r) begin
              go_r <= go_set;
              if (is_ceu || is_teu || is_mop || is_mip || is_aop || is_aip) begin
                busy_r <= 1'b1;
                O_UNIT <= instr_r[5:0];
                O_CHAR_MODE <= char_r;
                O_MEM_ADDR <= eff_addr;
                st_r <= ST_TEST;
              end else
                pc_r <= pc_r + 16'h0001;
            end
          end
          ST_TEST: begin
            if (is_teu || (sync_r && test_r)) begin
              st_r <= ST_XFER;
              O_BUS_OE <= out_dir;
              O_BUS_OUT <= is_aop ? (char_r ? {8'h00, accum_r[15:8]} : accum_r) :
                           (ind || is_mop) ? (char_r && is_mop ? {9'h000, oper_r[15:9]} : oper_r) : oper_r;
              O_CMD_STB <= is_ceu;
              O_TEST_STB <= is_teu;
              O_DOUT_STB <= is_mop || is_aop;
              O_DIN_STB <= is_mip || is_aip;
            end else if (!wait_md) begin
              st_r <= ST_DONE;
              skipped_r <= 1'b0;
              pc_r <= pc_r + 16'h0001;
            end
          end
          ST_XFER: begin
            st_r <= ST_DONE;
            O_BUS_OE <= 1'b0;
            if (is_aip) begin
              if (char_r)
                accum_r <= {merge ? accum_r[15:8] : 8'h00, din_r[7:0]};
              else
                accum_r <= {merge ? accum_r[15:8] : din_r[15:8], din_r[7:0]};
            end
            if (is_mip) begin
              O_MEM_WDATA <= char_r ? {9'h000, din_r[6:0]} : din_r;
              O_MEM_WE <= 1'b1;
            end
            if (is_teu) begin
              skipped_r <= test_r;
              pc_r <= pc_r + (test_r ? 16'h0002 : 16'h0001);
            end else begin
              skipped_r <= !wait_md;
              pc_r <= pc_r + (wait_md ? 16'h0001 : 16'h0002);
            end
          end
          default: begin
            st_r <= ST_IDLE;
            busy_r <= 1'b0;
            O_UNIT <= `UIX_UNIT_NONE;
          end
        endcase
      end
    end
  end
endmodule // uix_top

// ==== uix_chk.sv ====
// Assertions on the unit I/O executor top ports.
// Assumes MCYC_CLKS of at least 7 clocks.
`include "uix_regs.vh"
module uix_chk (
  input wire I_CLOCK, I_ARST_N, I_AWVALID, I_WVALID, O_AWREADY, O_WREADY, O_BVALID,
  input wire I_ARVALID, O_ARREADY, O_RVALID, O_BUS_OE, O_CMD_STB, O_TEST_STB, O_DOUT_STB, O_DIN_STB,
  input wire O_FORCE_VALID,
  input wire [5:0] O_UNIT,
  input wire [15:0] O_BUS_OUT, O_FORCE_INSTR
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  AST_RST_IDLE: assert property ($rose(I_ARST_N) |-> (O_UNIT == 6'h00 && !O_BUS_OE)[*2])
    else $error("unit selected after reset");
  AST_ONE_STB: assert property ($onehot0({O_CMD_STB, O_TEST_STB, O_DOUT_STB, O_DIN_STB}))
    else $error("two transfer strobes at once");
  AST_STB_OE: assert property (O_CMD_STB || O_TEST_STB || O_DOUT_STB |-> ##[0:1] O_BUS_OE)
    else $error("output strobe without bus drive");
  AST_BUS_HOLD: assert property ($rose(O_BUS_OE) |=> (O_BUS_OE && $stable(O_BUS_OUT))[*6])
    else $error("bus word not held");
  AST_UNIT_HOLD: assert property (O_BUS_OE && $past(O_BUS_OE) |-> $stable(O_UNIT))
    else $error("unit changed during transfer");
  AST_DIN_PULSE: assert property (O_DIN_STB |=> !O_DIN_STB)
    else $error("input strobe repeated");
  AST_FORCE: assert property (O_FORCE_VALID |-> O_FORCE_INSTR == `UIX_SPB_IND)
    else $error("wrong forced branch code");
  AST_WR_RESP: assert property (I_AWVALID && I_WVALID && O_AWREADY && O_WREADY |=> O_BVALID)
    else $error("write response missing");
  AST_RD_RESP: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read response missing");
endmodule // uix_chk
bind uix_top uix_chk uix_chk_inst (.*);

// ==== uix_unit_model.sv ====
// Behavioural peripheral unit on the shared I/O bus.
// Assumes the host holds its unit select while a unit is connected.
module uix_unit_model (
  input wire clk, // bench clock
  input wire [5:0] unit, // selected unit
  input wire [5:0] my_unit, // this unit's number
  input wire rdy, // able to transfer
  input wire [7:0] dly, // reply delay, clocks
  input wire [15:0] word, // word offered
  output logic [15:0] bus_in, // data to host
  output logic sync, // reply sync
  output logic test // reply test level
);
  logic [7:0] cnt = 8'h00;
  logic sel;
  assign sel = (unit == my_unit);
  initial {bus_in, sync, test} = 18'h0;
  always @(posedge clk) begin
    cnt <= sel ? cnt + 8'(cnt != 8'hFF) : 8'h00;
    sync <= sel && cnt >= dly;
    test <= sel && cnt >= dly && rdy;
    // released bus toggles so stale data cannot pass
    bus_in <= (sel && rdy) ? word : ~bus_in;
  end
endmodule // uix_unit_model

// ==== tb_uix_top.sv ====
// Self-checking bench for the unit I/O executor.
// Registers over AXI4-Lite; a unit model answers on the far side.
module tb_uix_top;
  timeunit 1ns;
  timeprecision 100ps;
  int n_fail = 0;
  int cmp_count = 0;
  int nstb = 0;
  int tick = 0;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, irq = 0, rdy = 0, chm = 0, lvl = 0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, c, rdata;
  logic [5:0] mu = 6'h00, unit, lu;
  logic [7:0] dly = 8'h00;
  logic [15:0] word = 16'h0, bus, lb, ld, fi, bin, mwd;
  logic [14:0] maddr, la, fa;
  logic aw_r, w_r, bv, ar_r, rv, oe, cs, ts, ds, dis, mwe, fv, sy, te, chr;
  uix_top #(.MCYC_CLKS(8)) uix_top_inst (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(aw_r), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(w_r), .O_BRESP(), .O_BVALID(bv),
    .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(ar_r), .O_RDATA(rdata), .O_RRESP(),
    .O_RVALID(rv), .I_RREADY(rr), .O_UNIT(unit), .O_BUS_OUT(bus), .O_BUS_OE(oe), .O_CMD_STB(cs),
    .O_TEST_STB(ts), .O_DOUT_STB(ds), .O_DIN_STB(dis), .O_CHAR_MODE(chr), .I_BUS_IN(bin), .I_RET_SYNC(sy),
    .I_RET_TEST(te), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwd), .O_MEM_WE(mwe), .I_IRQ(irq), .I_IRQ_LVL(lvl),
    .O_FORCE_ADDR(fa), .O_FORCE_INSTR(fi), .O_FORCE_VALID(fv));
  uix_unit_model uix_unit_model_inst (.clk(clk), .unit(unit), .my_unit(mu), .rdy(rdy), .dly(dly),
    .word(word), .bus_in(bin), .sync(sy), .test(te));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (oe) {lb, lu} <= {bus, unit};
    if (mwe) {la, ld} <= {maddr, mwd};
    if (cs | ts | ds | dis) nstb <= nstb + 1;
  end
  task results;
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  // One global budget bounds every wait
  task nx;
    @(negedge clk);
    tick++;
    if (tick > 20000) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    {ta, tw} = 2'b00;
    {awa, wd, awv, wv} <= {a, d, 2'b11};
    do begin
      nx();
      {ta, tw} = {ta | (aw_r & awv), tw | (w_r & wv)};
      @(posedge clk);
      {awv, wv} <= {awv & !ta, wv & !tw};
    end while (!(ta && tw));
    br <= 1'b1;
    do nx(); while (!bv);
    @(posedge clk);
    br <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    {ara, arv} <= {a, 1'b1};
    do nx(); while (!ar_r);
    @(posedge clk);
    {arv, rr} <= 2'b01;
    do nx(); while (!rv);
    d = rdata;
    @(posedge clk);
    rr <= 1'b0;
  endtask
  // Operand in low half; polls until done
  task ex(input logic [15:0] ins, input logic [15:0] op, input logic [15:0] pc);
    wr(4'h8, {16'h0, op});
    wr(4'h4, {16'h0, ins});
    wr(4'h0, {pc, 14'h0000, chm, 1'b1});
    do rd(4'h0, c); while (c[0] || c[2]);
  endtask
  task t_rst;
    @(negedge clk);
    chk(32'(unit), 32'h0);
    chk(32'(oe), 32'h0);
    @(posedge clk);
  endtask
  // Slow unit forces several wait cycles
  task t_aop;
    {mu, rdy, dly, word} = {6'h15, 1'b1, 8'd20, 16'h0};
    wr(4'hC, 32'h1234);
    ex(16'hF055, 16'h0, 16'h0100);
    chk(32'(lb), 32'h1234);
    chk(32'(lu), 32'h15);
    chk(32'(c[31:16]), 32'h0101);
  endtask
  task t_aip;
    {mu, rdy, dly, word} = {6'h25, 1'b1, 8'd0, 16'hFF34};
    wr(4'hC, 32'h5A00);
    ex(16'hF0A5, 16'h0, 16'h0100);
    chk(32'(c[31:16]), 32'h0102);
    rd(4'hC, c);
    chk(c, 32'hFF34);
    wr(4'hC, 32'h1200);
    ex(16'hF8A5, 16'h0, 16'h0100);
    rd(4'hC, c);
    chk(c, 32'h1234);
  endtask
  task t_ceu;
    int k;
    {mu, rdy, dly} = {6'h08, 1'b0, 8'd0};
    k = nstb;
    ex(16'hB008, 16'h00AA, 16'h0100);
    chk(32'(c[31:16]), 32'h0101);
    chk(nstb, k);
    {mu, rdy} = {6'h09, 1'b1};
    ex(16'hB049, 16'h00AA, 16'h0100);
    chk(32'(lb), 32'h00AA);
    chk(32'(c[31:16]), 32'h0101);
  endtask
  // Test code goes out whether or not the unit is ready
  task t_teu;
    {mu, rdy, dly} = {6'h0A, 1'b1, 8'd0};
    ex(16'hB08A, 16'h5555, 16'h0100);
    chk(32'(lb), 32'h5555);
    chk(32'(c[31:16]), 32'h0102);
    rdy = 1'b0;
    ex(16'hB08A, 16'h6666, 16'h0200);
    chk(32'(lb), 32'h6666);
    chk(32'(c[31:16]), 32'h0201);
  endtask
  task t_mip;
    {mu, rdy, dly, word} = {6'h0E, 1'b1, 8'd0, 16'h0BEE};
    ex(16'hFD8E, 16'h2345, 16'h4100);
    chk(32'(la), 32'h6345);
    chk(32'(ld), 32'h0BEE);
    chk(32'(c[31:16]), 32'h4102);
  endtask
  // Character units: only the character bits cross
  task t_chr;
    chm = 1'b1;
    {mu, rdy, dly, word} = {6'h33, 1'b1, 8'd0, 16'hFF34};
    ex(16'hF133, 16'hABCD, 16'h0100);
    chk(32'(lb), 32'h0055);
    chk(32'(chr), 32'h1);
    mu = 6'h25;
    wr(4'hC, 32'h5A00);
    ex(16'hF0A5, 16'h0, 16'h0100);
    rd(4'hC, c);
    chk(c, 32'h0034);
    wr(4'hC, 32'h8100);
    ex(16'hF025, 16'h0, 16'h0100);
    chk(32'(lb), 32'h0081);
    mu = 6'h0E;
    ex(16'hFD8E, 16'h2345, 16'h4100);
    chk(32'(ld), 32'h0034);
    chm = 1'b0;
  endtask
  task t_irq;
    {irq, lvl} <= 2'b11;
    do nx(); while (!fv);
    chk(32'(fi), 32'h9000);
    chk(32'(fa), 32'h0002);
    @(posedge clk);
    {irq, lvl} <= 2'b00;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_rst();
    t_aop();
    t_aip();
    t_ceu();
    t_teu();
    t_mip();
    t_chr();
    t_irq();
    results();
  end
endmodule // tb_uix_top
